// file: sau_consts.vh
`ifndef SAU_CONSTS_VH
`define SAU_CONSTS_VH
// register byte offsets, low address bits only
`define SAU_A_CTRL    5'h00
`define SAU_A_TYPE    5'h04
`define SAU_A_SELECT  5'h08
`define SAU_A_BASE    5'h0c
`define SAU_A_LIMIT   5'h10
`define SAU_A_FSTAT   5'h14
`define SAU_A_FADDR   5'h18
// region store
`define SAU_NREG      8
`define SAU_NREG_B    8'h08
`define SAU_IDX_W     3
`define SAU_ADDR_HI   31
`define SAU_ADDR_LO   5
`define SAU_LOW_ZERO  5'h00
`define SAU_LOW_ONES  5'h1f
// limit register fields
`define SAU_L_NSC     1
`define SAU_L_EN      0
// control register fields
`define SAU_C_ALL_MEMORY_NONSECURE   1
`define SAU_C_EN      0
// fault status bits
`define SAU_F_LAZYACT 7
`define SAU_F_AVALID  6
`define SAU_F_LAZYPRE 5
`define SAU_F_BADTRAN 4
`define SAU_F_AVIOL   3
`define SAU_F_BADRET  2
`define SAU_F_BADSIG  1
`define SAU_F_BADENT  0
`define SAU_F_W       8
// bus answers and protection bits
`define SAU_RESP_OK   2'h0
`define SAU_RESP_ERR  2'h2
`define SAU_PROT_PRIV 0
`define SAU_PROT_NS   1
`endif

// file: sau_attribution.v
// What this block does
// - select register holds 8-bit region index
// - region index undefined after warm reset
// - non-secure accesses read zero, writes ignored
// - one shared register copy, not banked
// - base holds address bits 31:5, low zero
// - limit holds bits 31:5, low bits ones
// - limit bit 1 marks non-secure callable
// - limit bit 0 enables selected region
// - status bit 7 lazy activation error
// - status bit 6 fault address valid
// - status bit 5 lazy preservation violation
// - status bit 4 bad domain transition
// - status bit 3 attribution violation, with exceptions
// - status bit 2 bad non-secure exception return
// - status bit 1 bad stack signature
// - status bit 0 bad secure entry point
// - fault address captures violating access address
// - overlapping regions give most secure attribute
// - only privileged access, unprivileged faults
// - disabled unit: all-nonsecure bit decides attribute
`timescale 1ns/1ps
`include "sau_consts.vh"

module sau_attribution (
  input  wire        clk,               // 50 MHz clock
  input  wire        rst_b,             // async reset, low
  input  wire [31:0] s_axi_awaddr,      // write address
  input  wire [2:0]  s_axi_awprot,      // write protection
  input  wire        s_axi_awvalid,     // write address valid
  output reg         s_axi_awready,     // write address ready
  input  wire [31:0] s_axi_wdata,       // write data
  input  wire [3:0]  s_axi_wstrb,       // write strobes
  input  wire        s_axi_wvalid,      // write data valid
  output reg         s_axi_wready,      // write data ready
  output reg  [1:0]  s_axi_bresp,       // write response
  output reg         s_axi_bvalid,      // write response valid
  input  wire        s_axi_bready,      // write response ready
  input  wire [31:0] s_axi_araddr,      // read address
  input  wire [2:0]  s_axi_arprot,      // read protection
  input  wire        s_axi_arvalid,     // read address valid
  output reg         s_axi_arready,     // read address ready
  output reg  [31:0] s_axi_rdata,       // read data
  output reg  [1:0]  s_axi_rresp,       // read response
  output reg         s_axi_rvalid,      // read data valid
  input  wire        s_axi_rready,      // read data ready
  input  wire [31:0] lk_addr,           // core lookup address
  output reg         lk_hit_q,          // lookup hit an enabled region
  output reg         lk_secure_q,       // lookup attribute secure
  output reg         lk_nsc_q,          // lookup non-secure callable
  input  wire [31:0] ev_addr,           // address of faulting access
  input  wire        ev_lazy_act_err,   // lazy activation error pulse
  input  wire        ev_attr_viol,      // attribution violation pulse
  input  wire        ev_in_lazy,        // violation during lazy preserve
  input  wire        ev_vector,         // violation on vector fetch
  input  wire        ev_bad_tran,       // unflagged secure to ns branch
  input  wire        ev_ns_return,      // exception return from ns
  input  wire        ev_ret_dcrs,       // default callee stacking bit
  input  wire        ev_ret_es,         // exception secure bit
  input  wire        ev_bad_sig,        // bad stack signature pulse
  input  wire        ev_ns_entry,       // ns call or exception entry
  input  wire        ev_entry_gateway,  // entry target is gateway
  input  wire        ev_other_exc,      // other fault clears valid
  output reg  [7:0]  fault_status_q,    // sticky fault flags
  output reg  [31:0] fault_addr_q       // captured fault address
);

  // ==========================================================
  // register state
  // ==========================================================
  reg [7:0]  sel_q;
  reg [26:0] base_q  [0:`SAU_NREG-1];
  reg [26:0] limit_q [0:`SAU_NREG-1];
  reg [`SAU_NREG-1:0] nsc_q;
  reg [`SAU_NREG-1:0] ren_q;
  reg        en_q;
  reg        all_memory_nonsecure_q;
  reg        aw_full_q;
  reg        w_full_q;
  reg [4:0]  aw_addr_q;
  reg [2:0]  aw_prot_q;
  reg [31:0] w_data_q;

  wire [`SAU_IDX_W-1:0] sidx = sel_q[`SAU_IDX_W-1:0];
  wire       sel_ok = (sel_q < `SAU_NREG_B);

  // region fields other than the enable and callable bits come out of reset unknown;
  // a region only takes part in matching once its enable is set, so
  // an unwritten window can never attribute an address.
  // software is expected to program base and limit before the enable.

  // ==========================================================
  // attribution and decode
  // ==========================================================
  // per-region window match, computed outside the function so that
  // every register the match depends on is seen as an operand and a
  // change of configuration is reflected at once.
  wire [`SAU_NREG-1:0] lk_m;
  wire [`SAU_NREG-1:0] ev_m;
  genvar r;
  generate
    for (r = 0; r < `SAU_NREG; r = r + 1) begin : g_match
      assign lk_m[r] = ren_q[r] &&
                       lk_addr >= {base_q[r], `SAU_LOW_ZERO} &&
                       lk_addr <= {limit_q[r], `SAU_LOW_ONES};
      assign ev_m[r] = ren_q[r] &&
                       ev_addr >= {base_q[r], `SAU_LOW_ZERO} &&
                       ev_addr <= {limit_q[r], `SAU_LOW_ONES};
    end
  endgenerate

  // returns {hit, secure, nsc} from the region matches
  // a callable match is the secure outcome, so it wins over any
  // plain non-secure region that overlaps it.
  function [2:0] attr;
    input [`SAU_NREG-1:0] m;
    input [`SAU_NREG-1:0] n;
    input                 e;
    input                 al;
    reg h;
    reg c;
    begin
      h = |m;
      c = |(m & n);
      if (!e)
        attr = {1'b0, ~al, 1'b0};
      else if (!h)
        attr = 3'b010;                               // no match: secure, not callable
      else
        attr = {1'b1, c, c};
    end
  endfunction

  // returns {mapped, error} for an access
  function [1:0] chk;
    input [4:0] a;
    input [2:0] p;
    reg m;
    begin
      m = (a == `SAU_A_CTRL) || (a == `SAU_A_TYPE) ||
          (a == `SAU_A_SELECT) || (a == `SAU_A_BASE) ||
          (a == `SAU_A_LIMIT) || (a == `SAU_A_FSTAT) ||
          (a == `SAU_A_FADDR);
      chk = {m, ~m | ~p[`SAU_PROT_PRIV]};
    end
  endfunction

  wire [2:0] lk_a = attr(lk_m, nsc_q, en_q, all_memory_nonsecure_q);
  wire [2:0] ev_a = attr(ev_m, nsc_q, en_q, all_memory_nonsecure_q);

  // ==========================================================
  // write channel
  // ==========================================================
  // address and data are parked in holding flops, taken in any order;
  // the register update happens one edge after both are present and
  // the response is raised at that same edge.
  // ready stays low on a channel while its item is parked, so a second
  // write cannot overtake the first.
  // the response is never raised while an earlier one still waits.
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs  = s_axi_wvalid & s_axi_wready;
  wire do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire [1:0] wchk = chk(aw_addr_q, aw_prot_q);
  // full-word writes assumed; strobes not decoded
  wire wr_ok = do_wr & ~wchk[0] & ~aw_prot_q[`SAU_PROT_NS];
  wire aw_full_d = do_wr ? 1'b0 : (aw_full_q | aw_hs);
  wire w_full_d  = do_wr ? 1'b0 : (w_full_q | w_hs);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 5'h00;
      aw_prot_q     <= 3'h0;
      w_data_q      <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SAU_RESP_OK;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      s_axi_awready <= ~aw_full_d;
      s_axi_wready  <= ~w_full_d;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr[4:0];
        aw_prot_q <= s_axi_awprot;
      end
      if (w_hs)
        w_data_q <= s_axi_wdata;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wchk[0] ? `SAU_RESP_ERR : `SAU_RESP_OK;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // control and region registers
  // ==========================================================
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q    <= 1'b0;
      all_memory_nonsecure_q <= 1'b0;
    end else if (wr_ok && aw_addr_q == `SAU_A_CTRL) begin
      en_q    <= w_data_q[`SAU_C_EN];
      all_memory_nonsecure_q <= w_data_q[`SAU_C_ALL_MEMORY_NONSECURE];
    end
  end

  // index has no reset: undefined until written
  // an index beyond the implemented regions selects nothing: base and
  // limit writes are dropped and reads return zero.
  always @(posedge clk) begin
    if (wr_ok && aw_addr_q == `SAU_A_SELECT)
      sel_q <= w_data_q[7:0];
  end

  genvar g;
  generate
    for (g = 0; g < `SAU_NREG; g = g + 1) begin : g_reg
      wire hit_w = wr_ok & sel_ok & (sidx == g);
      always @(posedge clk) begin
        if (hit_w && aw_addr_q == `SAU_A_BASE)
          base_q[g] <= w_data_q[`SAU_ADDR_HI:`SAU_ADDR_LO];
        if (hit_w && aw_addr_q == `SAU_A_LIMIT)
          limit_q[g] <= w_data_q[`SAU_ADDR_HI:`SAU_ADDR_LO];
      end
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          ren_q[g] <= 1'b0;
          nsc_q[g] <= 1'b0;
        end else if (hit_w && aw_addr_q == `SAU_A_LIMIT) begin
          nsc_q[g] <= w_data_q[`SAU_L_NSC];
          ren_q[g] <= w_data_q[`SAU_L_EN];
        end
      end
    end
  endgenerate

  // ==========================================================
  // fault status and address
  // ==========================================================
  // events are one-cycle pulses with their qualifiers alongside.
  // a set and a software clear in one cycle: the set wins, so no
  // fault raised while software is clearing the flags is lost.
  // the captured address follows the same priority over a write.
  // another exception clears only the address-valid flag.
  reg [7:0] set_m;
  reg [7:0] clr_m;
  wire bad_ent = ev_ns_entry & ev_a[1] & (~ev_entry_gateway | ~ev_a[0]);
  wire cap     = ev_attr_viol | bad_ent;

  always @* begin
    set_m = 8'h00;
    set_m[`SAU_F_LAZYACT] = ev_lazy_act_err;
    set_m[`SAU_F_AVALID]  = cap;
    set_m[`SAU_F_LAZYPRE] = ev_attr_viol & ev_in_lazy;
    set_m[`SAU_F_BADTRAN] = ev_bad_tran;
    set_m[`SAU_F_AVIOL]   = ev_attr_viol & ~ev_in_lazy & ~ev_vector;
    set_m[`SAU_F_BADRET]  = ev_ns_return & (~ev_ret_dcrs | ev_ret_es);
    set_m[`SAU_F_BADSIG]  = ev_bad_sig;
    set_m[`SAU_F_BADENT]  = bad_ent;
    clr_m = 8'h00;
    if (wr_ok && aw_addr_q == `SAU_A_FSTAT)
      clr_m = w_data_q[`SAU_F_W-1:0];
    clr_m[`SAU_F_AVALID] = clr_m[`SAU_F_AVALID] | ev_other_exc;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      fault_status_q <= 8'h00;
    else
      fault_status_q <= (fault_status_q & ~clr_m) | set_m;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      fault_addr_q <= 32'h0000_0000;
    else if (cap)
      fault_addr_q <= ev_addr;
    else if (wr_ok && aw_addr_q == `SAU_A_FADDR)
      fault_addr_q <= w_data_q;
  end

  // ==========================================================
  // read channel
  // ==========================================================
  // the read is decoded from the request itself and registered at
  // the accepting edge; arready drops until the data is taken, so the
  // held data cannot be overwritten by a following request.
  // unprivileged and unmapped reads answer with an error and zero.
  wire [1:0] rchk = chk(s_axi_araddr[4:0], s_axi_arprot);
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  reg [31:0] rd_v;

  always @* begin
    rd_v = 32'h0000_0000;
    case (s_axi_araddr[4:0])
      `SAU_A_CTRL:   rd_v = {30'h0, all_memory_nonsecure_q, en_q};
      `SAU_A_TYPE:   rd_v = {24'h0, `SAU_NREG_B};
      `SAU_A_SELECT: rd_v = {24'h0, sel_q};
      `SAU_A_BASE:   rd_v = sel_ok ? {base_q[sidx], `SAU_LOW_ZERO} : 32'h0;
      `SAU_A_LIMIT:  rd_v = sel_ok ? {limit_q[sidx], 3'h0, nsc_q[sidx],
                                      ren_q[sidx]} : 32'h0;
      `SAU_A_FSTAT:  rd_v = {24'h0, fault_status_q};
      `SAU_A_FADDR:  rd_v = fault_addr_q;
      default:       rd_v = 32'h0000_0000;
    endcase
    if (rchk[0] || s_axi_arprot[`SAU_PROT_NS])
      rd_v = 32'h0000_0000;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SAU_RESP_OK;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_v;
      s_axi_rresp   <= rchk[0] ? `SAU_RESP_ERR : `SAU_RESP_OK;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else
      s_axi_arready <= 1'b1;
  end

  // ==========================================================
  // core lookup port
  // ==========================================================
  // the answer is registered: it belongs to the address presented one
  // cycle earlier. during reset the attribute reads secure, the safe
  // default for any address.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_hit_q    <= 1'b0;
      lk_secure_q <= 1'b1;
      lk_nsc_q    <= 1'b0;
    end else begin
      lk_hit_q    <= lk_a[2];
      lk_secure_q <= lk_a[1];
      lk_nsc_q    <= lk_a[0];
    end
  end

endmodule // sau_attribution

// file: saf_attribution_properties.sv
`timescale 1ns/1ps
// ==========
// fault flag and register bus checks
module saf_chk (
  input wire        clk,             // clock
  input wire        rst_b,           // reset, low
  input wire        s_axi_bvalid,    // write answer
  input wire        s_axi_arvalid,   // read request
  input wire        s_axi_arready,   // read accept
  input wire [2:0]  s_axi_arprot,    // read protection
  input wire        s_axi_rvalid,    // read answer
  input wire [31:0] s_axi_rdata,     // read data
  input wire [1:0]  s_axi_rresp,     // read status
  input wire [31:0] ev_addr,         // event address
  input wire        ev_lazy_act_err, // lazy activation error
  input wire        ev_attr_viol,    // violation
  input wire        ev_in_lazy,      // during lazy preserve
  input wire        ev_vector,       // during vector fetch
  input wire        ev_bad_tran,     // bad transition
  input wire        ev_bad_sig,      // bad signature
  input wire [7:0]  fault_status_q,  // fault flags
  input wire [31:0] fault_addr_q     // fault address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence viol_plain;
    ev_attr_viol && !ev_in_lazy && !ev_vector;
  endsequence
  a_lazy_act_set: assert property (ev_lazy_act_err |=> fault_status_q[7])
    else $error("lazy activation flag not set");
  a_bad_tran_set: assert property (ev_bad_tran |=> fault_status_q[4])
    else $error("transition flag not set");
  a_bad_sig_set: assert property (ev_bad_sig |=> fault_status_q[1])
    else $error("signature flag not set");
  a_viol_flag_set: assert property (viol_plain |=> fault_status_q[3] && fault_status_q[6])
    else $error("violation flags not set");
  a_lazy_viol_set: assert property (ev_attr_viol && ev_in_lazy && !ev_vector
    |=> fault_status_q[5])
    else $error("lazy preservation flag not set");
  a_addr_capture: assert property (ev_attr_viol |=> fault_addr_q == $past(ev_addr))
    else $error("fault address not captured");
  a_sticky_clear: assert property ($fell(fault_status_q[4]) |-> $rose(s_axi_bvalid))
    else $error("flag cleared without a write");
  a_nonsec_zero: assert property (ar_take ##0 s_axi_arprot == 3'h3
    |=> s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0)
    else $error("non-secure read not zero");
  a_unpriv_err: assert property (ar_take ##0 !s_axi_arprot[0]
    |=> s_axi_rvalid && s_axi_rresp == 2'h2)
    else $error("unprivileged read not refused");
endmodule // saf_chk

// file: saf_core_model.sv
`timescale 1ns/1ps
// ==========
// core side: lookup addresses and one-cycle fault events
module saf_core (
  input  wire        clk,     // clock
  output reg  [31:0] lk_addr, // lookup address
  output reg  [31:0] ev_addr, // event address
  output reg  [11:0] ev       // events and qualifiers
);
  initial begin
    lk_addr = 32'h0;
    ev_addr = 32'h0;
    ev = 12'h000;
  end
  task fire(input [11:0] e, input [31:0] a);
    ev <= e;
    ev_addr <= a;
    @(posedge clk);
    ev <= 12'h000;
    // released address shows the inverse, not a stale value
    ev_addr <= ~a;
  endtask
  task look(input [31:0] a);
    lk_addr <= a;
    @(posedge clk);
  endtask
endmodule // saf_core

// file: tb_top.sv
`timescale 1ns/1ps
`include "sau_consts.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] lk_addr, ev_addr, fault_addr_q;
  logic [11:0] ev;
  logic [7:0]  fault_status_q;
  logic        lk_hit_q, lk_secure_q, lk_nsc_q;
  int          fail_count = 0, checks = 0;
  logic [11:0] ev_t [12] = '{12'h800, 12'h400, 12'h600, 12'h500, 12'h080, 12'h040,
                             12'h070, 12'h060, 12'h008, 12'h004, 12'h006, 12'h006};
  logic [7:0]  st_t [12] = '{8'h80, 8'h48, 8'h60, 8'h40, 8'h10, 8'h04,
                             8'h04, 8'h00, 8'h02, 8'h41, 8'h00, 8'h41};
  logic [31:0] la_t [8] = '{32'h1000, 32'h3000, 32'h3fff, 32'h2000, 32'h4000, 32'h8000,
                            32'h0fff, 32'h3000};
  logic [2:0]  le_t [8] = '{3'b111, 3'b100, 3'b100, 3'b111, 3'b111, 3'b010, 3'b010, 3'b010};
  always #10 clk = ~clk;
  saf_core core_u (.clk, .lk_addr, .ev_addr, .ev);
  sau_attribution dut_u (.*, .ev_lazy_act_err(ev[11]), .ev_attr_viol(ev[10]),
    .ev_in_lazy(ev[9]), .ev_vector(ev[8]), .ev_bad_tran(ev[7]), .ev_ns_return(ev[6]),
    .ev_ret_dcrs(ev[5]), .ev_ret_es(ev[4]), .ev_bad_sig(ev[3]), .ev_ns_entry(ev[2]),
    .ev_entry_gateway(ev[1]), .ev_other_exc(ev[0]));
  // ==========
  // bus and lookup tasks
  task wr(input [4:0] a, input [2:0] p, input [31:0] d, input [1:0] r);
    s_axi_awaddr  <= {27'h0, a};
    s_axi_awprot  <= p;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", r, s_axi_bresp)
    @(posedge clk);
  endtask
  task rd(input [4:0] a, input [2:0] p, input [31:0] e, input [1:0] r);
    s_axi_araddr  <= {27'h0, a};
    s_axi_arprot  <= p;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
    @(posedge clk);
  endtask
  task chk_lk(input [31:0] a, input [2:0] e);
    core_u.look(a);
    @(posedge clk);
    `CHK("hit secure nsc", e, {lk_hit_q, lk_secure_q, lk_nsc_q})
  endtask
  function automatic [31:0] rb(input int i);
    return (i == 7) ? 32'h1000 : 32'h1000 * (i + 1);
  endfunction
  function automatic [31:0] lim(input int i, input bit en);
    return (rb(i) + 32'hfe0) | {30'h0, i[0], en};
  endfunction
  task give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
  // ==========
  // tests
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_lk(32'h1000, 3'b010);
    rd(`SAU_A_FSTAT, 3'h1, 32'h0, 2'h0);
    wr(`SAU_A_CTRL, 3'h1, 32'h2, 2'h0);
    chk_lk(32'h1000, 3'b000);
    for (int i = 0; i < 8; i++) begin
      wr(`SAU_A_SELECT, 3'h1, i, 2'h0);
      wr(`SAU_A_BASE, 3'h1, rb(i) | 32'h1f, 2'h0);
      wr(`SAU_A_LIMIT, 3'h1, lim(i, 1'b1) | 32'h1c, 2'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(`SAU_A_SELECT, 3'h1, i, 2'h0);
      rd(`SAU_A_SELECT, 3'h1, i, 2'h0);
      rd(`SAU_A_BASE, 3'h1, rb(i), 2'h0);
      rd(`SAU_A_LIMIT, 3'h1, lim(i, 1'b1), 2'h0);
    end
    wr(`SAU_A_CTRL, 3'h1, 32'h3, 2'h0);
    for (int i = 0; i < 8; i++) begin
      if (i == 7) begin
        wr(`SAU_A_SELECT, 3'h1, 32'h2, 2'h0);
        wr(`SAU_A_LIMIT, 3'h1, lim(2, 1'b0), 2'h0);
      end
      chk_lk(la_t[i], le_t[i]);
    end
    rd(`SAU_A_CTRL, 3'h3, 32'h0, 2'h0);
    wr(`SAU_A_CTRL, 3'h3, 32'h0, 2'h0);
    rd(`SAU_A_CTRL, 3'h0, 32'h0, 2'h2);
    wr(`SAU_A_CTRL, 3'h0, 32'h0, 2'h2);
    rd(`SAU_A_CTRL, 3'h1, 32'h3, 2'h0);
    rd(5'h1c, 3'h1, 32'h0, 2'h2);
    for (int i = 0; i < 12; i++) begin
      wr(`SAU_A_FSTAT, 3'h1, 32'hff, 2'h0);
      core_u.fire(ev_t[i], (i == 10) ? 32'h2000 : 32'h8000 + 4 * i);
      rd(`SAU_A_FSTAT, 3'h1, {24'h0, st_t[i]}, 2'h0);
      if (st_t[i][6]) `CHK("fault addr", 32'h8000 + 4 * i, fault_addr_q)
    end
    wr(`SAU_A_FSTAT, 3'h1, 32'hff, 2'h0);
    core_u.fire(12'h808, 32'h0);
    rd(`SAU_A_FSTAT, 3'h1, 32'h82, 2'h0);
    core_u.fire(12'h400, 32'h9000);
    rd(`SAU_A_FSTAT, 3'h1, 32'hca, 2'h0);
    core_u.fire(12'h001, 32'h0);
    rd(`SAU_A_FSTAT, 3'h1, 32'h8a, 2'h0);
    wr(`SAU_A_FSTAT, 3'h1, 32'h80, 2'h0);
    rd(`SAU_A_FSTAT, 3'h1, 32'h0a, 2'h0);
    core_u.fire(12'h401, 32'ha000);
    rd(`SAU_A_FSTAT, 3'h1, 32'h4a, 2'h0);
    rd(`SAU_A_FADDR, 3'h1, 32'ha000, 2'h0);
    wr(`SAU_A_FADDR, 3'h1, 32'h1234_5678, 2'h0);
    rd(`SAU_A_FADDR, 3'h1, 32'h1234_5678, 2'h0);
    give_verdict;
  end
endmodule // tb_top
bind sau_attribution saf_chk chk_u (.clk, .rst_b, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_arprot, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .ev_addr,
  .ev_lazy_act_err, .ev_attr_viol, .ev_in_lazy, .ev_vector, .ev_bad_tran, .ev_bad_sig,
  .fault_status_q, .fault_addr_q);
